/* hdl/pap_pkg.sv */
//Function
// - Direction bit 1 makes a port line an output, 0 an input.
// - Reading port data passes input pin levels straight to the host, unlatched.
// - Side-A output register drives output lines, 1 high, 0 low.
// - Side-B data read returns output register for output lines, ignoring pin loading.
// - Side-A data read returns sensed pin levels even for output lines.
// - Input port lines leave their drivers off.
// - First control line is input only; its active edge sets flag bit 7.
// - Second control line programmed as input keeps its driver off.
// - Select 00 A data/dir, 01 A control, 10 B data/dir, 11 B control.
// - Control bit 2 set selects port data, cleared selects direction.
// - Reset clears all registers: lines inputs, interrupts disabled.
// - Control bits 0-5 read/write; bits 6-7 read-only event flags.
// - Bit 7 first flag, 6 second flag, 5-3 second line, 2 access, 1-0 first line.
// - Writes never set flags; port data read clears both side flags.
// - Control bit 1 picks first-line edge: 0 falling, 1 rising.
// - Control bit 0 gates flag 7 onto the open-drain request.
// - Flag set while disabled asserts the request once enable is written 1.
// - Bit 5 clear: second line input, bit 4 edge, bit 3 request enable.
// - Bit 5 set: second line is an output, behaviour differs per side.
// - A output, bit 4 clear: low after data read, high on flag or deselect.
// - B output, bit 4 clear: low after data write, high on flag or deselect.
// - Output mode with bit 4 set drives bit 3 statically.
package pap_pkg;

  localparam int PORT_W = 8;

  localparam logic [1:0] SEL_A_DATA = 2'h0;
  localparam logic [1:0] SEL_A_CTRL = 2'h1;
  localparam logic [1:0] SEL_B_DATA = 2'h2;
  localparam logic [1:0] SEL_B_CTRL = 2'h3;

  localparam int CB_FIRST_EN   = 0;
  localparam int CB_FIRST_EDGE = 1;
  localparam int CB_DATA_SEL   = 2;
  localparam int CB_AUX_B3     = 3;
  localparam int CB_AUX_B4     = 4;
  localparam int CB_AUX_OUT    = 5;

  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef struct packed {
    logic       enable;
    logic       cs0;
    logic       cs1;
    logic       cs2_n;
    logic [1:0] rs;
    logic       rd_wr_n;
    logic [7:0] wdata;
  } pap_host_req_t;

endpackage

/* hdl/pap_edge_flag.sv */
`timescale 1ns/100ps
`default_nettype none
module pap_edge_flag
  import pap_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic sample_i,
  input  wire logic line_i,
  input  wire logic rising_i,
  input  wire logic arm_i,
  input  wire logic clear_i,
  output logic      hit_o,
  output logic      flag_o
);
  logic prev;
  logic primed;

  // =====================================================
  // Edge sampling on enable, first sample only primes
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev   <= 1'b0;
      primed <= 1'b0;
    end
    else if (sample_i)
    begin
      prev   <= line_i;
      primed <= 1'b1;
    end
  end

  assign hit_o = sample_i && arm_i && primed &&
                 (rising_i ? (!prev && line_i) : (prev && !line_i));

  // =====================================================
  // Sticky flag, set wins over clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flag_o <= 1'b0;
    else if (hit_o)
      flag_o <= 1'b1;
    else if (clear_i)
      flag_o <= 1'b0;
  end
endmodule
`default_nettype wire

/* hdl/pap_aux_out.sv */
`timescale 1ns/100ps
`default_nettype none
module pap_aux_out
  import pap_pkg::*;
#(
  parameter bit SIDE_B = 1'b0
)
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       e_rise_i,
  input  wire logic       e_fall_i,
  input  wire logic       selected_i,
  input  wire logic [2:0] mode_i,
  input  wire logic       data_read_i,
  input  wire logic       data_write_i,
  input  wire logic       flag_hit_i,
  output logic            aux_o
);
  logic wr_pend;
  logic desel_prev;

  // =====================================================
  // Deselect and write tracking
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend    <= 1'b0;
      desel_prev <= 1'b0;
    end
    else
    begin
      if (e_fall_i)
        desel_prev <= !selected_i;
      if (data_write_i)
        wr_pend <= 1'b1;
      else if (e_rise_i)
        wr_pend <= 1'b0;
    end
  end

  // =====================================================
  // Aux output level
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      aux_o <= 1'b1;
    else if (mode_i[2] && mode_i[1])
      aux_o <= mode_i[0];
    else if (mode_i[2] && !SIDE_B)
    begin
      if (data_read_i)
        aux_o <= 1'b0;
      else if (!mode_i[0] && flag_hit_i)
        aux_o <= 1'b1;
      else if (mode_i[0] && e_fall_i && !selected_i)
        aux_o <= 1'b1;
    end
    else if (mode_i[2])
    begin
      if (e_rise_i && wr_pend)
        aux_o <= 1'b0;
      else if (!mode_i[0] && flag_hit_i)
        aux_o <= 1'b1;
      else if (mode_i[0] && e_rise_i && desel_prev)
        aux_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* hdl/pap_core.sv */
`timescale 1ns/100ps
`default_nettype none
module pap_core
  import pap_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  input  wire pap_pkg::pap_host_req_t host_i,
  output logic [7:0]                 host_rdata_o,
  output logic                       host_rdata_oe_o,
  input  wire logic [7:0]            side_a_lines_i,
  output logic [7:0]                 side_a_lines_o,
  output logic [7:0]                 side_a_lines_oe_o,
  input  wire logic [7:0]            side_b_lines_i,
  output logic [7:0]                 side_b_lines_o,
  output logic [7:0]                 side_b_lines_oe_o,
  input  wire logic                  side_a_request_input_i,
  input  wire logic                  side_b_request_input_i,
  input  wire logic                  side_a_aux_line_i,
  output logic                       side_a_aux_line_o,
  output logic                       side_a_aux_line_oe_o,
  input  wire logic                  side_b_aux_line_i,
  output logic                       side_b_aux_line_o,
  output logic                       side_b_aux_line_oe_o,
  output logic                       side_a_request_out_o,
  output logic                       side_a_request_out_oe_o,
  output logic                       side_b_request_out_o,
  output logic                       side_b_request_out_oe_o
);
  import pap_pkg::*;

  // =====================================================
  // Enable edge detection
  logic e_q;
  logic e_rise;
  logic e_fall;
  logic selected;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      e_q <= 1'b0;
    else
      e_q <= host_i.enable;
  end

  assign e_rise   = host_i.enable && !e_q;
  assign e_fall   = !host_i.enable && e_q;
  assign selected = host_i.cs0 && host_i.cs1 && !host_i.cs2_n;

  // =====================================================
  // Per-side arrays
  logic [1:0][7:0] lines_in;
  logic [1:0][7:0] out_reg;
  logic [1:0][7:0] dir_reg;
  logic [1:0][5:0] ctrl_reg;
  logic [1:0]      flag_first;
  logic [1:0]      flag_second;
  logic [1:0]      first_in;
  logic [1:0]      aux_in;
  logic [1:0]      aux_out;
  logic [1:0]      req_active;
  logic [1:0]      data_rd;

  assign lines_in = {side_b_lines_i, side_a_lines_i};
  assign first_in = {side_b_request_input_i, side_a_request_input_i};
  assign aux_in   = {side_b_aux_line_i, side_a_aux_line_i};

  genvar s;
  generate
    for (s = 0; s < 2; s++)
    begin : g_side
      logic       hit_first;
      logic       hit_second;
      logic       acc_data;
      logic       acc_ctrl;
      logic       wr_data;
      logic       wr_dir;
      logic       wr_ctrl;
      logic       rd_data;

      assign acc_data = e_fall && selected && (host_i.rs == (s == 0 ? SEL_A_DATA : SEL_B_DATA));
      assign acc_ctrl = e_fall && selected && (host_i.rs == (s == 0 ? SEL_A_CTRL : SEL_B_CTRL));
      assign wr_data  = acc_data && !host_i.rd_wr_n && ctrl_reg[s][CB_DATA_SEL];
      assign wr_dir   = acc_data && !host_i.rd_wr_n && !ctrl_reg[s][CB_DATA_SEL];
      assign wr_ctrl  = acc_ctrl && !host_i.rd_wr_n;
      assign rd_data  = acc_data && host_i.rd_wr_n && ctrl_reg[s][CB_DATA_SEL];
      assign data_rd[s] = rd_data;

      // Register writes
      always_ff @(posedge clk_sys_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          out_reg[s]  <= BYTE_RESET;
          dir_reg[s]  <= BYTE_RESET;
          ctrl_reg[s] <= CTRL_RESET;
        end
        else
        begin
          if (wr_data)
            out_reg[s] <= host_i.wdata;
          if (wr_dir)
            dir_reg[s] <= host_i.wdata;
          if (wr_ctrl)
            ctrl_reg[s] <= host_i.wdata[5:0];
        end
      end

      pap_edge_flag u_first
      (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .sample_i  (e_fall),
        .line_i    (first_in[s]),
        .rising_i  (ctrl_reg[s][CB_FIRST_EDGE]),
        .arm_i     (1'b1),
        .clear_i   (rd_data),
        .hit_o     (hit_first),
        .flag_o    (flag_first[s])
      );

      pap_edge_flag u_second
      (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .sample_i  (e_fall),
        .line_i    (aux_in[s]),
        .rising_i  (ctrl_reg[s][CB_AUX_B4]),
        .arm_i     (!ctrl_reg[s][CB_AUX_OUT]),
        .clear_i   (rd_data),
        .hit_o     (hit_second),
        .flag_o    (flag_second[s])
      );

      pap_aux_out #(
        .SIDE_B (s == 1)
      ) u_aux
      (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n_i),
        .e_rise_i     (e_rise),
        .e_fall_i     (e_fall),
        .selected_i   (selected),
        .mode_i       (ctrl_reg[s][CB_AUX_OUT:CB_AUX_B3]),
        .data_read_i  (rd_data),
        .data_write_i (wr_data),
        .flag_hit_i   (hit_first),
        .aux_o        (aux_out[s])
      );

      // Request level, live enable so a late enable still asserts
      assign req_active[s] = (flag_first[s] && ctrl_reg[s][CB_FIRST_EN]) ||
                             (flag_second[s] && ctrl_reg[s][CB_AUX_B3] &&
                              !ctrl_reg[s][CB_AUX_OUT]);
    end
  endgenerate

  // =====================================================
  // Host read data
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = BYTE_RESET;
    unique case (host_i.rs)
      SEL_A_DATA:
      begin
        if (ctrl_reg[0][CB_DATA_SEL])
          next_rdata = lines_in[0];
        else
          next_rdata = dir_reg[0];
      end
      SEL_A_CTRL:
        next_rdata = {flag_first[0], flag_second[0], ctrl_reg[0]};
      SEL_B_DATA:
      begin
        if (ctrl_reg[1][CB_DATA_SEL])
          next_rdata = (dir_reg[1] & out_reg[1]) | (~dir_reg[1] & lines_in[1]);
        else
          next_rdata = dir_reg[1];
      end
      SEL_B_CTRL:
        next_rdata = {flag_first[1], flag_second[1], ctrl_reg[1]};
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      host_rdata_o    <= BYTE_RESET;
      host_rdata_oe_o <= 1'b0;
    end
    else
    begin
      host_rdata_oe_o <= host_i.enable && selected && host_i.rd_wr_n;
      if (host_i.enable && selected && host_i.rd_wr_n)
        host_rdata_o <= next_rdata;
    end
  end

  // =====================================================
  // Pin drivers
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      side_a_lines_o       <= BYTE_RESET;
      side_a_lines_oe_o    <= BYTE_RESET;
      side_b_lines_o       <= BYTE_RESET;
      side_b_lines_oe_o    <= BYTE_RESET;
    end
    else
    begin
      side_a_lines_o       <= out_reg[0];
      side_a_lines_oe_o    <= dir_reg[0];
      side_b_lines_o       <= out_reg[1];
      side_b_lines_oe_o    <= dir_reg[1];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      side_a_aux_line_o       <= 1'b1;
      side_a_aux_line_oe_o    <= 1'b0;
      side_b_aux_line_o       <= 1'b1;
      side_b_aux_line_oe_o    <= 1'b0;
      side_a_request_out_o    <= 1'b0;
      side_a_request_out_oe_o <= 1'b0;
      side_b_request_out_o    <= 1'b0;
      side_b_request_out_oe_o <= 1'b0;
    end
    else
    begin
      side_a_aux_line_o       <= aux_out[0];
      side_a_aux_line_oe_o    <= ctrl_reg[0][CB_AUX_OUT];
      side_b_aux_line_o       <= aux_out[1];
      side_b_aux_line_oe_o    <= ctrl_reg[1][CB_AUX_OUT];
      side_a_request_out_o    <= 1'b0;
      side_a_request_out_oe_o <= req_active[0];
      side_b_request_out_o    <= 1'b0;
      side_b_request_out_oe_o <= req_active[1];
    end
  end
endmodule
`default_nettype wire

/* verification/pap_core_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module pap_core_chk
  import pap_pkg::*;
(
  input wire logic                   clk_sys_i,
  input wire logic                   rst_n_i,
  input wire pap_pkg::pap_host_req_t host_i,
  input wire logic [7:0]             side_a_lines_o,
  input wire logic [7:0]             side_a_lines_oe_o,
  input wire logic                   side_a_aux_line_o,
  input wire logic                   side_a_aux_line_oe_o,
  input wire logic                   side_b_aux_line_o,
  input wire logic                   side_a_request_out_o,
  input wire logic                   side_a_request_out_oe_o
);
  // ====================
  // Ages of host events
  logic       e_q;
  logic       tk;
  logic       wr;
  logic [5:0] ev;
  logic [2:0] age [6];
  assign tk = e_q & ~host_i.enable & host_i.cs0 & host_i.cs1 & ~host_i.cs2_n;
  assign wr = tk & ~host_i.rd_wr_n;
  assign ev = {wr & (host_i.rs == SEL_B_CTRL), ~e_q & host_i.enable, e_q & ~host_i.enable,
               wr & (host_i.rs == SEL_A_CTRL), wr & (host_i.rs == SEL_A_DATA),
               tk & host_i.rd_wr_n & (host_i.rs == SEL_A_DATA)};
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      e_q <= 1'b0;
      for (int i = 0; i < 6; i++)
        age[i] <= 3'h7;
    end
    else
    begin
      e_q <= host_i.enable;
      for (int i = 0; i < 6; i++)
        age[i] <= ev[i] ? 3'h0 : ((age[i] == 3'h7) ? 3'h7 : age[i] + 3'h1);
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_rst_idle;
    $rose(rst_n_i) |-> (side_a_lines_oe_o == 8'h00) && !side_a_aux_line_oe_o
                       && !side_a_request_out_oe_o && side_a_aux_line_o;
  endproperty
  property p_dir_a;
    $changed(side_a_lines_oe_o) |-> age[1] <= 3'h3;
  endproperty
  property p_out_a;
    $changed(side_a_lines_o) |-> age[1] <= 3'h3;
  endproperty
  property p_aux_oe;
    $changed(side_a_aux_line_oe_o) |-> age[2] <= 3'h3;
  endproperty
  property p_req_set;
    $rose(side_a_request_out_oe_o) |-> age[3] <= 3'h3;
  endproperty
  property p_req_clr;
    $fell(side_a_request_out_oe_o) |-> (age[0] <= 3'h3) || (age[2] <= 3'h3);
  endproperty
  property p_od;
    side_a_request_out_o == 1'b0;
  endproperty
  property p_aux_a;
    $fell(side_a_aux_line_o) |-> (age[0] <= 3'h3) || (age[2] <= 3'h3);
  endproperty
  property p_aux_b;
    $fell(side_b_aux_line_o) |-> (age[4] <= 3'h3) || (age[5] <= 3'h3);
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
  a_dir_a: assert property (p_dir_a) else $error("direction moved alone");
  a_out_a: assert property (p_out_a) else $error("output moved alone");
  a_aux_oe: assert property (p_aux_oe) else $error("aux enable moved alone");
  a_req_set: assert property (p_req_set) else $error("request off enable");
  a_req_clr: assert property (p_req_clr) else $error("request dropped alone");
  a_od: assert property (p_od) else $error("request pin not low");
  a_aux_a: assert property (p_aux_a) else $error("aux a fell alone");
  a_aux_b: assert property (p_aux_b) else $error("aux b fell alone");
  c_req: cover property ($rose(side_a_request_out_oe_o));
  c_aux_a: cover property ($fell(side_a_aux_line_o));
  c_aux_b: cover property ($fell(side_b_aux_line_o));
endmodule
bind pap_core pap_core_chk pap_core_chk_inst
(
  .clk_sys_i              (clk_sys_i),
  .rst_n_i                (rst_n_i),
  .host_i                 (host_i),
  .side_a_lines_o         (side_a_lines_o),
  .side_a_lines_oe_o      (side_a_lines_oe_o),
  .side_a_aux_line_o      (side_a_aux_line_o),
  .side_a_aux_line_oe_o   (side_a_aux_line_oe_o),
  .side_b_aux_line_o      (side_b_aux_line_o),
  .side_a_request_out_o   (side_a_request_out_o),
  .side_a_request_out_oe_o(side_a_request_out_oe_o)
);
`default_nettype wire

/* verification/pap_periph_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pap_periph_model
(
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] load_i,
  input  wire logic       aux_drv_i,
  input  wire logic       aux_oe_i,
  input  wire logic       aux_ext_i,
  output logic [7:0]      pin_o,
  output logic            aux_pin_o
);
  // ====================
  // Wire levels, heavy load pulls low
  assign pin_o = ((oe_i & drv_i) | (~oe_i & ext_i)) & ~load_i;
  assign aux_pin_o = aux_oe_i ? aux_drv_i : aux_ext_i;
endmodule
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pap_pkg::*;
  logic          clk_sys_i = 1'b0;
  logic          rst_n_i = 1'b0;
  pap_host_req_t host = '0;
  logic [7:0]    rdata, lo_a, oe_a, lo_b, oe_b, pin_a, pin_b, q;
  logic [7:0]    ext_a = 8'h3C, ext_b = 8'hC3, load_a = 8'h80, load_b = 8'h0F;
  logic          rq_a = 1'b0, rq_b = 1'b0, ax_a = 1'b0, ax_b = 1'b0;
  logic          xa, xa_oe, xb, xb_oe, pxa, pxb, ra_oe, rb_oe;
  int            err_total = 0, comparisons = 0, cyc = 0;
  // ====================
  // Design and far side
  pap_core pap_core_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .host_i(host),
    .host_rdata_o(rdata), .host_rdata_oe_o(), .side_a_lines_i(pin_a),
    .side_a_lines_o(lo_a), .side_a_lines_oe_o(oe_a), .side_b_lines_i(pin_b),
    .side_b_lines_o(lo_b), .side_b_lines_oe_o(oe_b), .side_a_request_input_i(rq_a),
    .side_b_request_input_i(rq_b), .side_a_aux_line_i(pxa), .side_a_aux_line_o(xa),
    .side_a_aux_line_oe_o(xa_oe), .side_b_aux_line_i(pxb), .side_b_aux_line_o(xb),
    .side_b_aux_line_oe_o(xb_oe), .side_a_request_out_o(), .side_a_request_out_oe_o(ra_oe),
    .side_b_request_out_o(), .side_b_request_out_oe_o(rb_oe));
  pap_periph_model pap_periph_model_inst (.drv_i(lo_a), .oe_i(oe_a), .ext_i(ext_a),
    .load_i(load_a), .aux_drv_i(xa), .aux_oe_i(xa_oe), .aux_ext_i(ax_a), .pin_o(pin_a),
    .aux_pin_o(pxa));
  pap_periph_model pap_periph_model_inst_b (.drv_i(lo_b), .oe_i(oe_b), .ext_i(ext_b),
    .load_i(load_b), .aux_drv_i(xb), .aux_oe_i(xb_oe), .aux_ext_i(ax_b), .pin_o(pin_b),
    .aux_pin_o(pxb));
  // ====================
  // Clock, timeout, tasks
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic acc(input logic [1:0] a, input logic r, input logic [7:0] d, input logic s);
    @(negedge clk_sys_i);
    host = '{enable: 1'b1, cs0: s, cs1: 1'b1, cs2_n: 1'b0, rs: a, rd_wr_n: r, wdata: d};
    repeat (4) @(negedge clk_sys_i);
    q = rdata;
    host.enable = 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    acc(a, 1'b0, d, 1'b1);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    acc(a, 1'b1, 8'h00, 1'b1);
    chk(q, exp);
  endtask
  task automatic ds();
    acc(SEL_A_DATA, 1'b1, 8'h00, 1'b0);
  endtask
  // ====================
  // Main sequence
  initial
  begin
    repeat (8) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    rd(SEL_A_CTRL, 8'h00);
    chk(oe_a | oe_b | {6'h00, xa_oe, xb_oe}, 8'h00);
    wr(SEL_A_DATA, 8'hF0);
    rd(SEL_A_DATA, 8'hF0);
    wr(SEL_A_CTRL, 8'hC4);
    rd(SEL_A_CTRL, 8'h04);
    chk(oe_a, 8'hF0);
    wr(SEL_A_DATA, 8'hA5);
    chk(lo_a, 8'hA5);
    rd(SEL_A_DATA, 8'h2C);
    wr(SEL_B_DATA, 8'h0F);
    wr(SEL_B_CTRL, 8'h04);
    wr(SEL_B_DATA, 8'h5A);
    rd(SEL_B_DATA, 8'hCA);
    load_a = 8'h00;
    load_b = 8'h00;
    wr(SEL_A_CTRL, 8'h05);
    rq_a = 1'b1;
    ds();
    rd(SEL_A_CTRL, 8'h05);
    rq_a = 1'b0;
    ds();
    rd(SEL_A_CTRL, 8'h85);
    chk({7'h00, ra_oe}, 8'h01);
    rd(SEL_A_DATA, 8'hAC);
    rd(SEL_A_CTRL, 8'h05);
    chk({7'h00, ra_oe}, 8'h00);
    wr(SEL_B_CTRL, 8'h06);
    rq_b = 1'b1;
    ds();
    rd(SEL_B_CTRL, 8'h86);
    chk({7'h00, rb_oe}, 8'h00);
    wr(SEL_B_CTRL, 8'h07);
    chk({7'h00, rb_oe}, 8'h01);
    rd(SEL_B_DATA, 8'hCA);
    chk({7'h00, rb_oe}, 8'h00);
    wr(SEL_A_CTRL, 8'h1C);
    chk({7'h00, xa_oe}, 8'h00);
    ax_a = 1'b1;
    ds();
    rd(SEL_A_CTRL, 8'h5C);
    chk({7'h00, ra_oe}, 8'h01);
    rd(SEL_A_DATA, 8'hAC);
    wr(SEL_A_CTRL, 8'h3C);
    chk({6'h00, xa_oe, pxa}, 8'h03);
    wr(SEL_A_CTRL, 8'h34);
    chk({6'h00, xa_oe, pxa}, 8'h02);
    wr(SEL_A_CTRL, 8'h24);
    rq_a = 1'b1;
    ds();
    rq_a = 1'b0;
    ds();
    chk({7'h00, xa}, 8'h01);
    rd(SEL_A_DATA, 8'hAC);
    chk({7'h00, xa}, 8'h00);
    wr(SEL_A_CTRL, 8'h2C);
    ds();
    chk({7'h00, xa}, 8'h01);
    wr(SEL_B_CTRL, 8'h26);
    wr(SEL_B_DATA, 8'h33);
    ds();
    chk({7'h00, xb}, 8'h00);
    rq_b = 1'b0;
    ds();
    rq_b = 1'b1;
    ds();
    chk({7'h00, xb}, 8'h01);
    rd(SEL_B_CTRL, 8'hA6);
    chk(lo_b, 8'h33);
    wr(SEL_B_CTRL, 8'h2E);
    wr(SEL_B_DATA, 8'h44);
    ds();
    chk({7'h00, xb}, 8'h00);
    ds();
    chk({7'h00, xb}, 8'h01);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    rd(SEL_B_CTRL, 8'h00);
    chk(oe_a | oe_b, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
